// ---- acgen_checker.sv ----
`default_nettype none
module acgen_checker
    import acgen_pkg::*;
(
    input wire logic              I_CLOCK,
    input wire logic              I_RST_B,
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic              I_WR,
    input wire logic              I_RD,
    input wire logic [DATA_W-1:0] I_WDATA,
    input wire logic [DATA_W-1:0] O_RDATA,
    input wire logic [FREQ_W-1:0] O_SYNTH_WORD
);
    logic [DATA_W-1:0] div_q;
    logic [DATA_W-1:0] div_d;
    always_comb
    begin
        div_d = div_q;
        if (I_WR && I_ADDR == ADDR_DIVIDER)
            div_d = I_WDATA & DIV_WRITE_MASK;
    end
    always_ff @(posedge I_CLOCK or negedge I_RST_B)
    begin
        if (!I_RST_B)
            div_q <= RESET_BYTE;
        else
            div_q <= div_d;
    end
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_B);
    chk_freq_low_byte: assert property (I_WR && I_ADDR == ADDR_FREQ_BYTE0
        |-> ##2 O_SYNTH_WORD[7:0] == $past(I_WDATA, 2)) else $error("byte0 not in word");
    chk_freq_mid_byte: assert property (I_WR && I_ADDR == ADDR_FREQ_BYTE1
        |-> ##2 O_SYNTH_WORD[15:8] == $past(I_WDATA, 2)) else $error("byte1 not in word");
    chk_freq_high_byte: assert property (I_WR && I_ADDR == ADDR_FREQ_BYTE2
        |-> ##2 O_SYNTH_WORD[23:16] == $past(I_WDATA, 2)) else $error("byte2 not in word");
    chk_word_needs_write: assert property (O_SYNTH_WORD != $past(O_SYNTH_WORD)
        |-> $past(I_WR, 2) && $past(I_ADDR, 2) >= ADDR_FREQ_BYTE2
        && $past(I_ADDR, 2) <= ADDR_FREQ_BYTE0) else $error("word changed unasked");
    chk_high_readback: assert property (I_RD && I_ADDR == ADDR_FREQ_BYTE2
        |=> O_RDATA == O_SYNTH_WORD[23:16]) else $error("byte2 read differs");
    chk_div_reserved_zero: assert property (I_RD && I_ADDR == ADDR_DIVIDER
        |=> !O_RDATA[3]) else $error("divider bit3 set");
    chk_div_fields_back: assert property (I_RD && I_ADDR == ADDR_DIVIDER
        |=> O_RDATA == $past(div_q)) else $error("divider read differs");
    chk_unmapped_zero: assert property (I_RD && !I_WR
        && (I_ADDR < ADDR_CONTROL || I_ADDR > ADDR_FREQ_BYTE0)
        |=> O_RDATA == UNMAPPED_DATA) else $error("unmapped read not zero");
endmodule : acgen_checker
bind acgen_top acgen_checker u_acgen_checker (.I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B),
    .I_ADDR(I_ADDR), .I_WR(I_WR), .I_RD(I_RD), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA),
    .O_SYNTH_WORD(O_SYNTH_WORD));
`default_nettype wire

// ---- acgen_codec_model.sv ----
`default_nettype none
// Two master clock sources on the codec side, free running and both started together at 7 ns
module acgen_codec_model #(
    parameter int HALF_A_NS = 100,
    parameter int HALF_B_NS = 150
)
(
    input  wire logic        i_mclk,
    input  wire logic        i_mclk2,
    output var  logic        o_mclk_a,
    output var  logic        o_mclk_b,
    output wire logic [31:0] o_rises,
    output wire logic [31:0] o_rises2
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] rise_q  = '0;
    logic [31:0] rise2_q = '0;
    // The codec only sees the clocks it is fed, so it counts their rising edges
    always @(posedge i_mclk) rise_q <= rise_q + 1;
    always @(posedge i_mclk2) rise2_q <= rise2_q + 1;
    assign o_rises  = rise_q;
    assign o_rises2 = rise2_q;
    initial
    begin
        o_mclk_a = 1'b0;
        o_mclk_b = 1'b0;
        #7;
        fork
            forever #(HALF_A_NS) o_mclk_a = ~o_mclk_a;
            forever #(HALF_B_NS) o_mclk_b = ~o_mclk_b;
        join
    end
endmodule : acgen_codec_model
`default_nettype wire

// ---- acgen_cycle_counter.sv ----
`default_nettype none
module acgen_cycle_counter
    import acgen_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_rst_b,
    input  wire logic               i_count,
    input  wire logic               i_frame,
    output logic [COUNT_W-1:0]      o_capture
);
    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] count_d;
    logic [COUNT_W-1:0] cap_q;
    logic [COUNT_W-1:0] cap_d;

    always_comb
    begin
        count_d = count_q;
        cap_d   = cap_q;
        if (i_count)
        begin
            count_d = count_q + 1'b1;
        end
        // Whole word taken at once so the bytes never tear
        if (i_frame)
        begin
            cap_d = count_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            count_q <= '0;
            cap_q   <= '0;
        end
        else
        begin
            count_q <= count_d;
            cap_q   <= cap_d;
        end
    end

    assign o_capture = cap_q;
endmodule : acgen_cycle_counter
`default_nettype wire

// ---- acgen_divider.sv ----
`default_nettype none
module acgen_divider
    import acgen_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_rst_b,
    input  wire logic               i_enable,
    input  wire logic               i_tick,
    input  wire logic [RATIO_W-1:0] i_ratio,
    output logic                    o_rise,
    output logic                    o_clk
);
    logic [RATIO_W-1:0] cnt_q;
    logic [RATIO_W-1:0] cnt_d;
    logic               clk_q;
    logic               clk_d;
    logic               rise_q;
    logic               rise_d;

    // Each input tick is a half period; ratio counts ticks before a toggle
    always_comb
    begin
        cnt_d  = cnt_q;
        clk_d  = clk_q;
        rise_d = 1'b0;
        if (!i_enable)
        begin
            cnt_d = '0;
            clk_d = 1'b0;
        end
        else if (i_tick)
        begin
            // Ratio may shrink mid-count, so wrap on greater or equal
            if (cnt_q >= i_ratio)
            begin
                cnt_d  = '0;
                clk_d  = !clk_q;
                rise_d = !clk_q;
            end
            else
            begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt_q  <= '0;
            clk_q  <= 1'b0;
            rise_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            clk_q  <= clk_d;
            rise_q <= rise_d;
        end
    end

    assign o_rise = rise_q;
    assign o_clk  = clk_q;
endmodule : acgen_divider
`default_nettype wire

// ---- acgen_pkg.sv ----
`default_nettype none
package acgen_pkg;
    localparam int            ADDR_W           = 16;
    localparam int            DATA_W           = 8;
    localparam int            FREQ_W           = 24;
    localparam int            COUNT_W          = 16;
    localparam int            RATIO_W          = 4;
    localparam int            SYNC_STAGES      = 3;

    localparam logic [15:0]   ADDR_CONTROL     = 16'hffe1;
    localparam logic [15:0]   ADDR_DIVIDER     = 16'hffe2;
    localparam logic [15:0]   ADDR_CAP_HIGH    = 16'hffe3;
    localparam logic [15:0]   ADDR_CAP_LOW     = 16'hffe4;
    localparam logic [15:0]   ADDR_FREQ_BYTE2  = 16'hffe5;
    localparam logic [15:0]   ADDR_FREQ_BYTE1  = 16'hffe6;
    localparam logic [15:0]   ADDR_FREQ_BYTE0  = 16'hffe7;

    localparam logic [7:0]    RESET_BYTE       = 8'h00;
    localparam logic [7:0]    UNMAPPED_DATA    = 8'h00;

    // Control register fields
    localparam int            CTL_OUT_EN_BIT   = 6;
    localparam int            CTL_CAP_SEL_BIT  = 5;
    localparam int            CTL_IN_SEL_BIT   = 4;
    localparam int            CTL_DIV_EN_BIT   = 2;
    localparam logic [7:0]    CTL_WRITE_MASK   = 8'h74;

    // Divider register fields
    localparam int            DIV_OUT_MSB      = 7;
    localparam int            DIV_OUT_LSB      = 4;
    localparam int            DIV_IN_MSB       = 2;
    localparam int            DIV_IN_LSB       = 0;
    localparam logic [7:0]    DIV_WRITE_MASK   = 8'hf7;
endpackage : acgen_pkg
`default_nettype wire

// ---- acgen_top.sv ----
`default_nettype none
module acgen_top
    import acgen_pkg::*;
(
    input  wire logic               I_CLOCK,
    input  wire logic               I_RST_B,
    input  wire logic [ADDR_W-1:0]  I_ADDR,
    input  wire logic               I_WR,
    input  wire logic               I_RD,
    input  wire logic [DATA_W-1:0]  I_WDATA,
    output logic      [DATA_W-1:0]  O_RDATA,
    input  wire logic               I_SOF,
    input  wire logic               I_MCLK_IN,
    input  wire logic               I_MCLK_IN2,
    output logic                    O_MCLK_OUT,
    output logic                    O_MCLK_OUT_EN,
    output logic                    O_MCLK_OUT_SECONDARY,
    output logic      [FREQ_W-1:0]  O_SYNTH_WORD
);
    logic [DATA_W-1:0]      ctl_q;
    logic [DATA_W-1:0]      ctl_d;
    logic [DATA_W-1:0]      div_q;
    logic [DATA_W-1:0]      div_d;
    logic [DATA_W-1:0]      frq2_q;
    logic [DATA_W-1:0]      frq2_d;
    logic [DATA_W-1:0]      frq1_q;
    logic [DATA_W-1:0]      frq1_d;
    logic [DATA_W-1:0]      frq0_q;
    logic [DATA_W-1:0]      frq0_d;
    logic [DATA_W-1:0]      rdata_q;
    logic [DATA_W-1:0]      rdata_d;
    logic [FREQ_W-1:0]      word_q;
    logic [FREQ_W-1:0]      acc_q;
    logic [FREQ_W-1:0]      acc_d;
    logic                   synth_tick_q;
    logic                   synth_tick_d;
    logic [SYNC_STAGES-1:0] sync1_q;
    logic [SYNC_STAGES-1:0] sync1_d;
    logic [SYNC_STAGES-1:0] sync2_q;
    logic [SYNC_STAGES-1:0] sync2_d;
    logic                   lvl1_q;
    logic                   lvl1_d;
    logic                   lvl2_q;
    logic                   lvl2_d;
    logic                   in_prev_q;
    logic                   in_prev_d;
    logic                   in_tick;
    logic                   in_level;
    logic                   out_q;
    logic                   out_d;
    logic                   out2_q;
    logic                   out2_d;
    logic                   out_en_q;
    logic                   out_en_d;
    logic                   prim_rise;
    logic                   prim_clk;
    logic                   sec_rise;
    logic                   sec_clk;
    logic                   count_en;
    logic [COUNT_W-1:0]     capture;
    logic [FREQ_W:0]        acc_sum;

    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] target);
        hit = (addr == target);
    endfunction : hit

    function automatic logic [DATA_W-1:0] masked(input logic [DATA_W-1:0] old_v,
                                                 input logic [DATA_W-1:0] new_v,
                                                 input logic [DATA_W-1:0] mask);
        masked = (old_v & ~mask) | (new_v & mask);
    endfunction : masked

    // Register writes
    always_comb
    begin
        ctl_d  = ctl_q;
        div_d  = div_q;
        frq2_d = frq2_q;
        frq1_d = frq1_q;
        frq0_d = frq0_q;
        if (I_WR)
        begin
            if (hit(I_ADDR, ADDR_CONTROL))
            begin
                // Enable is honoured as written; ordering is software's job
                ctl_d = masked(ctl_q, I_WDATA, CTL_WRITE_MASK);
            end
            if (hit(I_ADDR, ADDR_DIVIDER))
            begin
                div_d = masked(div_q, I_WDATA, DIV_WRITE_MASK);
            end
            if (hit(I_ADDR, ADDR_FREQ_BYTE2))
            begin
                frq2_d = I_WDATA;
            end
            if (hit(I_ADDR, ADDR_FREQ_BYTE1))
            begin
                frq1_d = I_WDATA;
            end
            if (hit(I_ADDR, ADDR_FREQ_BYTE0))
            begin
                frq0_d = I_WDATA;
            end
        end
    end

    // Register reads, answered one cycle after the strobe
    always_comb
    begin
        rdata_d = rdata_q;
        if (I_RD)
        begin
            rdata_d = UNMAPPED_DATA;
            if (hit(I_ADDR, ADDR_CONTROL))
            begin
                rdata_d = ctl_q;
            end
            if (hit(I_ADDR, ADDR_DIVIDER))
            begin
                rdata_d = div_q;
            end
            if (hit(I_ADDR, ADDR_CAP_HIGH))
            begin
                rdata_d = capture[15:8];
            end
            if (hit(I_ADDR, ADDR_CAP_LOW))
            begin
                rdata_d = capture[7:0];
            end
            if (hit(I_ADDR, ADDR_FREQ_BYTE2))
            begin
                rdata_d = frq2_q;
            end
            if (hit(I_ADDR, ADDR_FREQ_BYTE1))
            begin
                rdata_d = frq1_q;
            end
            if (hit(I_ADDR, ADDR_FREQ_BYTE0))
            begin
                rdata_d = frq0_q;
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            ctl_q   <= RESET_BYTE;
            div_q   <= RESET_BYTE;
            frq2_q  <= RESET_BYTE;
            frq1_q  <= RESET_BYTE;
            frq0_q  <= RESET_BYTE;
            rdata_q <= RESET_BYTE;
        end
        else
        begin
            ctl_q   <= ctl_d;
            div_q   <= div_d;
            frq2_q  <= frq2_d;
            frq1_q  <= frq1_d;
            frq0_q  <= frq0_d;
            rdata_q <= rdata_d;
        end
    end

    // Phase accumulator; each carry is one half period of the synth clock
    assign acc_sum = {1'b0, acc_q} + {1'b0, word_q};

    always_comb
    begin
        acc_d        = acc_sum[FREQ_W-1:0];
        synth_tick_d = acc_sum[FREQ_W];
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            word_q       <= '0;
            acc_q        <= '0;
            synth_tick_q <= 1'b0;
        end
        else
        begin
            word_q       <= {frq2_q, frq1_q, frq0_q};
            acc_q        <= acc_d;
            synth_tick_q <= synth_tick_d;
        end
    end

    // Pin inputs: three stages, level accepted once the last two agree
    always_comb
    begin
        sync1_d   = {sync1_q[SYNC_STAGES-2:0], I_MCLK_IN};
        sync2_d   = {sync2_q[SYNC_STAGES-2:0], I_MCLK_IN2};
        lvl1_d    = (sync1_q[2] == sync1_q[1]) ? sync1_q[2] : lvl1_q;
        lvl2_d    = (sync2_q[2] == sync2_q[1]) ? sync2_q[2] : lvl2_q;
        in_level  = ctl_q[CTL_IN_SEL_BIT] ? lvl2_q : lvl1_q;
        in_prev_d = in_level;
        // Both edges count, as the divider works in half periods
        in_tick   = (in_level != in_prev_q);
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            sync1_q   <= '0;
            sync2_q   <= '0;
            lvl1_q    <= 1'b0;
            lvl2_q    <= 1'b0;
            in_prev_q <= 1'b0;
        end
        else
        begin
            sync1_q   <= sync1_d;
            sync2_q   <= sync2_d;
            lvl1_q    <= lvl1_d;
            lvl2_q    <= lvl2_d;
            in_prev_q <= in_prev_d;
        end
    end

    acgen_divider u_out_div (
        .i_clk    (I_CLOCK),
        .i_rst_b  (I_RST_B),
        .i_enable (ctl_q[CTL_DIV_EN_BIT]),
        .i_tick   (synth_tick_q),
        .i_ratio  (div_q[DIV_OUT_MSB:DIV_OUT_LSB]),
        .o_rise   (prim_rise),
        .o_clk    (prim_clk)
    );

    acgen_divider u_in_div (
        .i_clk    (I_CLOCK),
        .i_rst_b  (I_RST_B),
        .i_enable (ctl_q[CTL_DIV_EN_BIT]),
        .i_tick   (in_tick),
        .i_ratio  ({1'b0, div_q[DIV_IN_MSB:DIV_IN_LSB]}),
        .o_rise   (sec_rise),
        .o_clk    (sec_clk)
    );

    // One count per rising edge of the chosen master clock
    assign count_en = ctl_q[CTL_CAP_SEL_BIT] ? sec_rise : prim_rise;

    acgen_cycle_counter u_counter (
        .i_clk     (I_CLOCK),
        .i_rst_b   (I_RST_B),
        .i_count   (count_en),
        .i_frame   (I_SOF),
        .o_capture (capture)
    );

    always_comb
    begin
        out_d    = prim_clk;
        out2_d   = sec_clk;
        out_en_d = ctl_q[CTL_OUT_EN_BIT];
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            out_q    <= 1'b0;
            out2_q   <= 1'b0;
            out_en_q <= 1'b0;
        end
        else
        begin
            out_q    <= out_d;
            out2_q   <= out2_d;
            out_en_q <= out_en_d;
        end
    end

    assign O_RDATA              = rdata_q;
    assign O_MCLK_OUT           = out_q;
    assign O_MCLK_OUT_EN        = out_en_q;
    assign O_MCLK_OUT_SECONDARY = out2_q;
    assign O_SYNTH_WORD         = word_q;
endmodule : acgen_top
`default_nettype wire

// ---- test_adaptive_audio_clock_gen_regs.sv ----
`default_nettype none
module test_adaptive_audio_clock_gen_regs
    import acgen_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WIN = 4096;
    // Control, divider and expected counter clock period in core cycles
    localparam logic [7:0] CFG_CTL [5] = '{8'h64, 8'h64, 8'h74, 8'h44, 8'h44};
    localparam logic [7:0] CFG_DIV [5] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'hf0};
    localparam int         CFG_PER [5] = '{8, 64, 12, 4, 64};
    // Expected primary and secondary output periods in core cycles
    localparam int         CFG_PRI [5] = '{4, 4, 4, 4, 64};
    localparam int         CFG_SEC [5] = '{8, 64, 12, 8, 8};
    logic        clk = 1'b0;
    logic        rst_b;
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        sof;
    logic        mclk_a;
    logic        mclk_b;
    logic        mclk_out;
    logic        mclk_out2;
    logic        mclk_en;
    logic [31:0] rises;
    logic [31:0] rises2;
    logic [23:0] synth;
    logic [7:0]  v;
    logic [15:0] d;
    int          mismatches = 0;
    int          n_checks = 0;
    always #12.5 clk = ~clk;
    acgen_codec_model u_acgen_codec_model (.i_mclk(mclk_out), .i_mclk2(mclk_out2),
        .o_mclk_a(mclk_a), .o_mclk_b(mclk_b), .o_rises(rises), .o_rises2(rises2));
    acgen_top u_acgen_top (.I_CLOCK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WR(wr),
        .I_RD(rd), .I_WDATA(wdata), .O_RDATA(rdata), .I_SOF(sof), .I_MCLK_IN(mclk_a),
        .I_MCLK_IN2(mclk_b), .O_MCLK_OUT(mclk_out), .O_MCLK_OUT_EN(mclk_en),
        .O_MCLK_OUT_SECONDARY(mclk_out2),
        .O_SYNTH_WORD(synth));
    task wr_reg(input logic [15:0] a, input logic [7:0] x);
        @(posedge clk);
        addr <= a;
        wdata <= x;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [15:0] a, output logic [7:0] x);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 x = rdata;
    endtask : rd_reg
    task check(input logic [23:0] got, input logic [23:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
            mismatches++;
        end
    endtask : check
    task pulse_sof();
        @(posedge clk);
        sof <= 1'b1;
        @(posedge clk);
        sof <= 1'b0;
    endtask : pulse_sof
    // Counts between two frames, read as high byte then low byte
    task measure(output logic [15:0] n);
        logic [7:0]  h;
        logic [7:0]  l;
        logic [15:0] c1;
        pulse_sof();
        rd_reg(ADDR_CAP_HIGH, h);
        rd_reg(ADDR_CAP_LOW, l);
        c1 = {h, l};
        repeat (WIN - 6) @(posedge clk);
        pulse_sof();
        rd_reg(ADDR_CAP_HIGH, h);
        rd_reg(ADDR_CAP_LOW, l);
        n = {h, l} - c1;
    endtask : measure
    // Rising edges the codec sees on both outputs over one window
    task count_rises(input int i);
        logic [31:0] p0;
        logic [31:0] s0;
        logic [31:0] n_p;
        logic [31:0] n_s;
        @(posedge clk);
        p0 = rises;
        s0 = rises2;
        repeat (WIN) @(posedge clk);
        n_p = rises - p0;
        n_s = rises2 - s0;
        n_checks += 2;
        if ($isunknown(n_p) || n_p + 1 < WIN / CFG_PRI[i]
            || n_p > WIN / CFG_PRI[i] + 1)
        begin
            $display("MISMATCH t=%0t config %0d primary rises %0d", $time, i, n_p);
            mismatches++;
        end
        if ($isunknown(n_s) || n_s + 1 < WIN / CFG_SEC[i]
            || n_s > WIN / CFG_SEC[i] + 1)
        begin
            $display("MISMATCH t=%0t config %0d secondary rises %0d", $time, i, n_s);
            mismatches++;
        end
    endtask : count_rises
    task wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    initial
    begin
        #2_000_000;
        $display("MISMATCH t=%0t watchdog expired", $time);
        mismatches++;
        wrap_up();
    end
    initial
    begin
        rst_b = 1'b0;
        addr = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h00;
        sof = 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = ADDR_CONTROL; a <= ADDR_FREQ_BYTE0; a++)
        begin
            rd_reg(a[15:0], v);
            check(v, RESET_BYTE, "reset value");
        end
        rd_reg(16'hffe0, v);
        check(v, UNMAPPED_DATA, "unmapped");
        wr_reg(ADDR_FREQ_BYTE2, 8'h12);
        wr_reg(ADDR_FREQ_BYTE1, 8'h34);
        wr_reg(ADDR_FREQ_BYTE0, 8'h56);
        rd_reg(ADDR_FREQ_BYTE1, v);
        check(v, 8'h34, "byte1 back");
        check(synth, 24'h12_3456, "synth word");
        wr_reg(ADDR_DIVIDER, 8'hff);
        rd_reg(ADDR_DIVIDER, v);
        check(v, 8'hf7, "divider back");
        wr_reg(ADDR_CAP_HIGH, 8'haa);
        wr_reg(ADDR_CAP_LOW, 8'h55);
        rd_reg(ADDR_CAP_HIGH, v);
        check(v, 8'h00, "cap high written");
        rd_reg(ADDR_CAP_LOW, v);
        check(v, 8'h00, "cap low written");
        wr_reg(ADDR_CONTROL, 8'hff);
        rd_reg(ADDR_CONTROL, v);
        check(v, CTL_WRITE_MASK, "control back");
        check(mclk_en, 1'b1, "out enable on");
        wr_reg(ADDR_CONTROL, 8'h00);
        rd_reg(ADDR_CONTROL, v);
        check(mclk_en, 1'b0, "out enable off");
        $display("test registers done");
        // Synth tick every second cycle gives a primary period of four cycles per M
        wr_reg(ADDR_FREQ_BYTE2, 8'h80);
        wr_reg(ADDR_FREQ_BYTE1, 8'h00);
        wr_reg(ADDR_FREQ_BYTE0, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            wr_reg(ADDR_CONTROL, CFG_CTL[i] & 8'hfb);
            wr_reg(ADDR_DIVIDER, CFG_DIV[i]);
            wr_reg(ADDR_CONTROL, CFG_CTL[i]);
            repeat (200) @(posedge clk);
            measure(d);
            n_checks++;
            // Phase of the counter clock against the frames allows one count either way
            if ($isunknown(d) || d + 1 < WIN / CFG_PER[i] || d > WIN / CFG_PER[i] + 1)
            begin
                $display("MISMATCH t=%0t config %0d count %0d", $time, i, d);
                mismatches++;
            end
            count_rises(i);
            $display("test counter config %0d done", i);
        end
        wrap_up();
    end
endmodule : test_adaptive_audio_clock_gen_regs
`default_nettype wire
